// file: sim/cfs_host_model.sv
// Host model that watches the open-drain status and event pins
`timescale 1ns/10ps
module cfs_host_model
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        stat_line,
	input  wire logic        event_line,
	output logic      [15:0] low_len,
	output logic      [15:0] diff_cnt
);
	// ---
	// Pin sampling
	// ---
	logic [15:0] run_r;

	// Time each low stretch; a released pin reads high by its pull-up
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			run_r <= 16'h0000;
			low_len <= 16'h0000;
			diff_cnt <= 16'h0000;
		end
		else
		begin
			run_r <= stat_line ? 16'h0000 : run_r + 16'h0001;
			if (stat_line && run_r != 16'h0000)
				low_len <= run_r;
			if (event_line !== stat_line)
				diff_cnt <= diff_cnt + 16'h0001;
		end
endmodule

// file: sim/cfs_monitor.sv
// Assertion checker for the charger fault and status supervisor
`timescale 1ns/10ps
module cfs_monitor
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       thermistor_monitor_enable,
	input wire logic       stat_enable,
	input wire logic       die_temp_over_shut,
	input wire logic       input_sleep_cmp,
	input wire logic       input_lockout_cmp,
	input wire logic       input_ovp_cmp,
	input wire logic       input_droop_cmp,
	input wire logic       converter_on,
	input wire logic       discharge_gate_drive,
	input wire logic       timers_run,
	input wire logic       input_droop_flag,
	input wire logic [2:0] fault_code,
	input wire logic [1:0] supply_status,
	input wire logic [1:0] battery_temp_status,
	input wire logic       stat_out,
	input wire logic       stat_oe,
	input wire logic       event_out,
	input wire logic       event_oe
);
	// ---
	// Pulse length count
	// ---
	logic [15:0] len_r;
	logic [15:0] len_nxt;

	// Cycles the status pin has been pulled low so far
	assign len_nxt = stat_oe ? len_r + 16'h0001 : 16'h0000;
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
			len_r <= 16'h0000;
		else
			len_r <= len_nxt;

	// ---
	// Properties
	// ---
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_TS_OFF: assert property (
		(!thermistor_monitor_enable)[*3] |-> battery_temp_status == 2'h0)
		else $error("battery temperature status not normal");
	AST_MIRROR: assert property (
		stat_oe == event_oe && stat_out == event_out)
		else $error("event pin differs from status pin");
	// A restarted pulse may run longer, never shorter
	AST_PULSE_LEN: assert property (
		$fell(stat_oe) && !stat_enable |-> len_r >= 16'h3200)
		else $error("event pulse too short");
	AST_SHUT_OFF: assert property (
		die_temp_over_shut[*5] |-> (!converter_on && !timers_run
			&& fault_code == 3'h1))
		else $error("thermal shutdown not applied");
	AST_SHUT_PULSE: assert property (
		$rose(fault_code == 3'h1) |-> ##[0:2] stat_oe)
		else $error("no pulse on thermal shutdown");
	AST_SLEEP: assert property (
		converter_on ##1 (input_sleep_cmp && !input_lockout_cmp
			&& !die_temp_over_shut)[*3] |-> ##[0:3] (!converter_on
			&& !discharge_gate_drive))
		else $error("sleep entry wrong");
	AST_OVP: assert property (
		converter_on ##1 (input_ovp_cmp && !input_sleep_cmp
			&& !die_temp_over_shut)[*3] |-> ##[0:3] (discharge_gate_drive
			&& supply_status == 2'h1 && fault_code == 3'h5))
		else $error("overvoltage response wrong");
	AST_DROOP: assert property (
		(input_droop_cmp && converter_on)[*4] |-> input_droop_flag)
		else $error("droop flag not set");
endmodule

// file: sim/cfs_supervisor_tb_top.sv
// Self-checking testbench for the charger fault and status supervisor
`timescale 1ns/10ps
module cfs_supervisor_tb_top;
	// ---
	// Signals and instances
	// ---
	logic clk, reset_n, source_attach, die_temp_reg_hit, die_temp_hot10;
	logic die_temp_over_shut, die_temp_cool10, input_sleep_cmp;
	logic input_lockout_cmp, input_droop_cmp, input_badsrc_cmp;
	logic input_ovp_cmp, thermistor_sense_in, thermistor_monitor_enable;
	logic stat_enable, charge_disable, ext_event, converter_on;
	logic battery_switch_on, discharge_gate_drive, test_load_on;
	logic timers_run, input_limit_reduced, input_droop_flag;
	logic stat_out, stat_oe, event_out, event_oe;
	logic [2:0] ext_fault_code, state_code_bits, fault_code;
	logic [7:0] charge_current_limit;
	logic [1:0] supply_status, battery_temp_status;
	logic [15:0] low_len, diff_cnt;
	logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	// Open-drain pins with pull-ups
	wire stat_line = stat_oe ? stat_out : 1'b1;
	wire event_line = event_oe ? event_out : 1'b1;

	// Short detection and retry counts keep the run brief
	cfs_supervisor #(.DETECT_CYC(50), .RETRY_CYC(100)) cfs_supervisor_inst (.*);
	cfs_host_model cfs_host_model_inst (.*);

	// ---
	// Clock, timeout and tasks
	// ---
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cut a hang short well past the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			summarize();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait: sel 0 for converter on, sel 1 for pin release
	task automatic wait_for(input bit sel, input int lim);
		int n;
		n = 0;
		while ((sel ? stat_oe !== 1'b0 : converter_on !== 1'b1) && n < lim)
		begin
			cyc(1);
			n++;
		end
		chk(n < lim, 1'h1);
	endtask

	task summarize();
		$display("Comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ---
	// Test sequence
	// ---
	initial
	begin
		{source_attach, die_temp_reg_hit, die_temp_hot10, die_temp_over_shut,
			die_temp_cool10, input_sleep_cmp, input_lockout_cmp,
			input_droop_cmp, input_badsrc_cmp, input_ovp_cmp, charge_disable,
			ext_event, ext_fault_code, stat_enable} = '0;
		thermistor_monitor_enable = 1'b1;
		thermistor_sense_in = 1'b1;
		reset_n = 1'b0;
		cyc(4);
		reset_n = 1'b1;
		thermistor_monitor_enable = 1'b0;
		cyc(4);
		chk(battery_temp_status, 2'h0);
		input_badsrc_cmp = 1'b1;
		source_attach = 1'b1;
		cyc(8);
		chk(test_load_on, 1'h0);
		chk(fault_code, 3'h5);
		chk(supply_status, 2'h2);
		input_badsrc_cmp = 1'b0;
		cyc(120);
		chk(test_load_on, 1'h1);
		wait_for(0, 200);
		chk(fault_code, 3'h0);
		chk(state_code_bits, 3'h3);
		input_droop_cmp = 1'b1;
		cyc(5);
		chk(input_limit_reduced, 1'h1);
		input_droop_cmp = 1'b0;
		die_temp_reg_hit = 1'b1;
		cyc(20);
		chk(charge_current_limit < 8'h80, 1'h1);
		die_temp_hot10 = 1'b1;
		cyc(5);
		chk(charge_current_limit, 8'h00);
		{die_temp_reg_hit, die_temp_hot10} = 2'b00;
		wait_for(1, 14000);
		die_temp_over_shut = 1'b1;
		cyc(5);
		chk(fault_code, 3'h1);
		chk(stat_line, 1'h0);
		wait_for(1, 13000);
		cyc(2);
		chk(low_len, 16'h3200);
		die_temp_over_shut = 1'b0;
		die_temp_cool10 = 1'b1;
		wait_for(0, 300);
		die_temp_cool10 = 1'b0;
		// Sleep, overvoltage and bad source in turn
		for (int k = 0; k < 3; k++)
		begin
			{input_sleep_cmp, input_ovp_cmp, input_badsrc_cmp} = 3'b100 >> k;
			cyc(6);
			chk(converter_on, 1'h0);
			chk(battery_switch_on, 1'h1);
			chk(discharge_gate_drive, k != 0);
			chk(fault_code, 3'h5);
			chk(stat_line, 1'h0);
			if (k == 1)
				chk(supply_status, 2'h1);
			// Lockout while asleep reports the lockout supply code
			if (k == 0)
			begin
				input_lockout_cmp = 1'b1;
				cyc(4);
				chk(supply_status, 2'h3);
				input_lockout_cmp = 1'b0;
			end
			{input_sleep_cmp, input_ovp_cmp, input_badsrc_cmp} = 3'b000;
			wait_for(0, 300);
			chk(fault_code, 3'h0);
			chk(supply_status, 2'h0);
		end
		stat_enable = 1'b1;
		cyc(13000);
		chk(stat_line, 1'h0);
		chk(diff_cnt, 16'h0000);
		charge_disable = 1'b1;
		cyc(10);
		chk(stat_line, 1'h1);
		for (int k = 0; k < 4; k++)
		begin
			ext_fault_code = codes[k];
			ext_event = 1'b1;
			cyc(1);
			ext_event = 1'b0;
			cyc(4);
			chk(fault_code, codes[k]);
		end
		summarize();
	end
endmodule

bind cfs_supervisor cfs_monitor cfs_monitor_inst (.*);

// file: verilog/cfs_defs.vh
// Constants for the charger fault and status supervisor
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

// Timing, 100 MHz clock
`define CFS_CLK_MHZ        100
`define CFS_PULSE_US       128
`define CFS_PULSE_CYC      (`CFS_PULSE_US * `CFS_CLK_MHZ)
`define CFS_DETECT_MS      32
`define CFS_DETECT_CYC     (`CFS_DETECT_MS * 1000 * `CFS_CLK_MHZ)
`define CFS_RETRY_S        2
`define CFS_RETRY_CYC      (`CFS_RETRY_S * 1000000 * `CFS_CLK_MHZ)

// Supervisor states
`define CFS_ST_IDLE        3'h0
`define CFS_ST_DETECT      3'h1
`define CFS_ST_RETRY       3'h2
`define CFS_ST_RUN         3'h3
`define CFS_ST_SLEEP       3'h4
`define CFS_ST_SHUT        3'h5
`define CFS_ST_BADSRC      3'h6
`define CFS_ST_OVP         3'h7

// State codes
`define CFS_SC_NOSRC       3'h0
`define CFS_SC_READY       3'h1
`define CFS_SC_CHARGING    3'h3
`define CFS_SC_FAULT       3'h7

// Fault codes
`define CFS_FC_NORMAL      3'h0
`define CFS_FC_THERMAL     3'h1
`define CFS_FC_BATTEMP     3'h2
`define CFS_FC_WATCHDOG    3'h3
`define CFS_FC_SAFETY      3'h4
`define CFS_FC_SUPPLY      3'h5
`define CFS_FC_BATTERY     3'h7

// Supply status codes
`define CFS_SS_NORMAL      2'h0
`define CFS_SS_OVP         2'h1
`define CFS_SS_WEAK        2'h2
`define CFS_SS_UVLO        2'h3

// Battery temperature status
`define CFS_BT_NORMAL      2'h0

// Charge current limit levels: full, zero and droop
`define CFS_ILIM_FULL      8'hff
`define CFS_ILIM_ZERO      8'h00
`define CFS_ILIM_DROOP     8'h80

`endif

// file: verilog/cfs_supervisor.v
// Charger fault and status supervisor: sequencing, codes, event pulse

`timescale 1ns/10ps
`include "cfs_defs.vh"

module cfs_supervisor
#(
	parameter DETECT_CYC = `CFS_DETECT_CYC,
	parameter RETRY_CYC  = `CFS_RETRY_CYC
)
(
	input  wire       clk,
	input  wire       reset_n,
	input  wire       source_attach,
	input  wire       die_temp_reg_hit,
	input  wire       die_temp_hot10,
	input  wire       die_temp_over_shut,
	input  wire       die_temp_cool10,
	input  wire       input_sleep_cmp,
	input  wire       input_lockout_cmp,
	input  wire       input_droop_cmp,
	input  wire       input_badsrc_cmp,
	input  wire       input_ovp_cmp,
	input  wire       thermistor_sense_in,
	input  wire       thermistor_monitor_enable,
	input  wire       stat_enable,
	input  wire       charge_disable,
	input  wire       ext_event,
	input  wire [2:0] ext_fault_code,
	output reg        converter_on,
	output reg        battery_switch_on,
	output reg        discharge_gate_drive,
	output reg        test_load_on,
	output reg        timers_run,
	output reg  [7:0] charge_current_limit,
	output reg        input_limit_reduced,
	output reg        input_droop_flag,
	output reg  [2:0] state_code_bits,
	output reg  [2:0] fault_code,
	output reg  [1:0] supply_status,
	output reg  [1:0] battery_temp_status,
	output reg        stat_out,
	output reg        stat_oe,
	output reg        event_out,
	output reg        event_oe
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	reg  [9:0] sync1_r;
	reg  [9:0] sync2_r;
	wire [9:0] raw_in;
	reg        attach_d_r;

	assign raw_in = {die_temp_hot10, die_temp_reg_hit, thermistor_sense_in,
		input_ovp_cmp, input_badsrc_cmp, input_droop_cmp,
		input_lockout_cmp, input_sleep_cmp, die_temp_over_shut,
		die_temp_cool10};

	// Two flops per comparator; attach is a synchronous pin
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_r    <= 10'h000;
			sync2_r    <= 10'h000;
			attach_d_r <= 1'b0;
		end
		else
		begin
			sync1_r    <= raw_in;
			sync2_r    <= sync1_r;
			attach_d_r <= source_attach;
		end
	end

	wire s_hot   = sync2_r[9];
	wire s_reg   = sync2_r[8];
	wire s_ts    = sync2_r[7];
	wire s_ovp   = sync2_r[6];
	wire s_bad   = sync2_r[5];
	wire s_droop = sync2_r[4];
	wire s_uvlo  = sync2_r[3];
	wire s_sleep = sync2_r[2];
	wire s_shut  = sync2_r[1];
	wire s_cool  = sync2_r[0];

	// ------------------------------------------------------------
	// Supervisor state machine
	// ------------------------------------------------------------
	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [27:0] tmr_r;
	reg  [27:0] tmr_nxt;
	reg         ev_nxt;
	reg  [2:0]  fc_nxt;
	reg  [1:0]  ss_nxt;
	wire        attach_edge;
	wire        sleep_cond;

	assign attach_edge = source_attach & ~attach_d_r;
	assign sleep_cond  = s_sleep & ~s_uvlo;

	// Next state; thermal shutdown overrides every state
	always @*
	begin
		state_nxt = state_r;
		tmr_nxt   = tmr_r;
		ev_nxt    = 1'b0;
		fc_nxt    = fault_code;
		ss_nxt    = supply_status;
		if (s_shut && state_r != `CFS_ST_SHUT)
		begin
			state_nxt = `CFS_ST_SHUT;
			ev_nxt    = 1'b1;
			fc_nxt    = `CFS_FC_THERMAL;
		end
		else if (attach_edge && state_r != `CFS_ST_SHUT)
		begin
			state_nxt = `CFS_ST_DETECT;
			tmr_nxt   = 28'h0;
			ev_nxt    = 1'b1;
			fc_nxt    = `CFS_FC_NORMAL;
			ss_nxt    = `CFS_SS_NORMAL;
		end
		else if (ext_event)
		begin
			ev_nxt = 1'b1;
			fc_nxt = ext_fault_code;
		end
		else
		begin
			case (state_r)
			`CFS_ST_IDLE:
				tmr_nxt = 28'h0;
			`CFS_ST_DETECT:
			begin
				tmr_nxt = tmr_r + 28'h1;
				if (s_bad)
				begin
					state_nxt = `CFS_ST_RETRY;
					tmr_nxt   = 28'h0;
					ev_nxt    = 1'b1;
					fc_nxt    = `CFS_FC_SUPPLY;
					ss_nxt    = `CFS_SS_WEAK;
				end
				else if (tmr_r >= DETECT_CYC - 1)
				begin
					if (!s_ovp)
					begin
						state_nxt = `CFS_ST_RUN;
						fc_nxt    = `CFS_FC_NORMAL;
						ss_nxt    = `CFS_SS_NORMAL;
					end
					else
						tmr_nxt = 28'h0;
				end
			end
			`CFS_ST_RETRY:
			begin
				tmr_nxt = tmr_r + 28'h1;
				if (tmr_r >= RETRY_CYC - 1)
				begin
					state_nxt = `CFS_ST_DETECT;
					tmr_nxt   = 28'h0;
				end
			end
			`CFS_ST_RUN:
			begin
				if (sleep_cond)
				begin
					state_nxt = `CFS_ST_SLEEP;
					ev_nxt    = 1'b1;
					fc_nxt    = `CFS_FC_SUPPLY;
				end
				else if (s_ovp)
				begin
					state_nxt = `CFS_ST_OVP;
					ev_nxt    = 1'b1;
					fc_nxt    = `CFS_FC_SUPPLY;
					ss_nxt    = `CFS_SS_OVP;
				end
				else if (s_bad)
				begin
					state_nxt = `CFS_ST_BADSRC;
					ev_nxt    = 1'b1;
					fc_nxt    = `CFS_FC_SUPPLY;
					ss_nxt    = `CFS_SS_WEAK;
				end
			end
			`CFS_ST_SLEEP:
				if (!s_sleep)
				begin
					state_nxt = `CFS_ST_RUN;
					fc_nxt    = `CFS_FC_NORMAL;
					ss_nxt    = `CFS_SS_NORMAL;
				end
				else if (s_uvlo)
					ss_nxt = `CFS_SS_UVLO;
			`CFS_ST_BADSRC:
				if (!s_bad)
				begin
					state_nxt = `CFS_ST_RUN;
					fc_nxt    = `CFS_FC_NORMAL;
					ss_nxt    = `CFS_SS_NORMAL;
				end
			`CFS_ST_OVP:
				if (!s_ovp)
				begin
					state_nxt = `CFS_ST_RUN;
					fc_nxt    = `CFS_FC_NORMAL;
					ss_nxt    = `CFS_SS_NORMAL;
				end
			`CFS_ST_SHUT:
				if (s_cool && !s_shut)
				begin
					state_nxt = `CFS_ST_RUN;
					fc_nxt    = `CFS_FC_NORMAL;
				end
			default:
				state_nxt = `CFS_ST_IDLE;
			endcase
		end
	end

	// State, codes and power-path drives
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r              <= `CFS_ST_IDLE;
			tmr_r                <= 28'h0;
			fault_code           <= `CFS_FC_NORMAL;
			supply_status        <= `CFS_SS_NORMAL;
			state_code_bits      <= `CFS_SC_NOSRC;
			converter_on         <= 1'b0;
			battery_switch_on    <= 1'b1;
			discharge_gate_drive <= 1'b1;
			test_load_on         <= 1'b0;
			timers_run           <= 1'b0;
		end
		else
		begin
			state_r       <= state_nxt;
			tmr_r         <= tmr_nxt;
			fault_code    <= fc_nxt;
			supply_status <= ss_nxt;
			converter_on  <= (state_nxt == `CFS_ST_RUN);
			test_load_on  <= (state_nxt == `CFS_ST_DETECT);
			timers_run    <= (state_nxt == `CFS_ST_RUN);
			battery_switch_on <= 1'b1;
			// Gate pulled low in sleep, on for other faults
			discharge_gate_drive <= (state_nxt != `CFS_ST_RUN) &&
				(state_nxt != `CFS_ST_SLEEP);
			case (state_nxt)
			`CFS_ST_RUN:
				state_code_bits <= charge_disable ?
					`CFS_SC_READY : `CFS_SC_CHARGING;
			`CFS_ST_IDLE, `CFS_ST_DETECT:
				state_code_bits <= `CFS_SC_NOSRC;
			default:
				state_code_bits <= `CFS_SC_FAULT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Charge current taper and input droop
	// ------------------------------------------------------------
	// Linear taper between regulation point and 10 C above it
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			charge_current_limit <= `CFS_ILIM_FULL;
			input_limit_reduced  <= 1'b0;
			input_droop_flag     <= 1'b0;
			battery_temp_status  <= `CFS_BT_NORMAL;
		end
		else
		begin
			if (state_r != `CFS_ST_RUN || s_hot)
				charge_current_limit <= `CFS_ILIM_ZERO;
			else if (s_reg)
			begin
				if (charge_current_limit != `CFS_ILIM_ZERO)
					charge_current_limit <=
						charge_current_limit - 8'h01;
			end
			else if (s_droop)
				charge_current_limit <= `CFS_ILIM_DROOP;
			else if (charge_current_limit != `CFS_ILIM_FULL)
				charge_current_limit <= charge_current_limit + 8'h01;
			input_limit_reduced <= s_droop && state_r == `CFS_ST_RUN;
			input_droop_flag    <= s_droop && state_r == `CFS_ST_RUN;
			// Thermistor result only reported while monitoring is on
			battery_temp_status <= thermistor_monitor_enable ?
				{1'b0, s_ts} : `CFS_BT_NORMAL;
		end
	end

	// ------------------------------------------------------------
	// Event pulse and status pins
	// ------------------------------------------------------------
	reg [13:0] pulse_r;
	wire       pulse_busy;
	wire       charging;
	wire       pin_low;
	localparam [31:0] PULSE_LOAD = `CFS_PULSE_CYC - 1;

	assign pulse_busy = (pulse_r != 14'h0);
	assign charging   = (state_r == `CFS_ST_RUN) && !charge_disable;
	// A new event restarts the count, so every pulse is full length
	assign pin_low    = ev_nxt || pulse_busy ||
		(charging && stat_enable);

	// Count and pins together; pins only ever pull low, data stays zero
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pulse_r   <= 14'h0;
			stat_out  <= 1'b0;
			stat_oe   <= 1'b0;
			event_out <= 1'b0;
			event_oe  <= 1'b0;
		end
		else
		begin
			// Loaded one short: the load cycle already pulls the pin low
			if (ev_nxt)
				pulse_r <= PULSE_LOAD[13:0];
			else if (pulse_busy)
				pulse_r <= pulse_r - 14'h1;
			stat_out  <= 1'b0;
			stat_oe   <= pin_low;
			event_out <= 1'b0;
			event_oe  <= pin_low;
		end
	end

endmodule
